// file: shared/lds_pkg.sv
package lds_pkg;
	// clock and link timing
	localparam int CLK_NS = 5;
	localparam int SCLK_HALF_NS = 80;
	// least time, so round up to whole cycles
	localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [4:0] HALF_LAST = 5'(HALF_CYC - 1);
	// frame layout: 3 address bits on top of 12 data bits
	localparam int FRAME_BITS = 15;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 12;
	localparam int CODE_W = 6;
	localparam logic [3:0] BIT_LAST = 4'(FRAME_BITS - 1);
	localparam logic [2:0] REG_COUNT = 3'h5;
	// device register indices
	localparam logic [2:0] RA_ROUTE = 3'h0;
	localparam logic [2:0] RA_PAIR = 3'h1;
	localparam logic [2:0] RA_CODES = 3'h2;
	localparam logic [2:0] RA_CHD = 3'h3;
	localparam logic [2:0] RA_CMD = 3'h4;
	// device field positions
	localparam int TEST_HI = 11;
	localparam int TEST_LO = 10;
	localparam int ROUTE_HI = 9;
	localparam int PAIR_LO = 6;
	localparam int CODE_HI_LSB = 6;
	localparam int CODE_LO_LSB = 0;
	localparam logic [3:0] ROUTE_ONLY_HI = 4'h8;
	localparam logic [1:0] ROUTE_LO_ONLY = 2'h1;
	// lowest usable converter codes
	localparam logic [5:0] VOLT_MIN = 6'h14;
	localparam logic [5:0] CURR_MIN = 6'h0a;
	// own register map, byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FRAME = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [2:0] OFS_SHADOW_HI = 3'h1;
	// control register bits
	localparam int CT_PS = 0;
	localparam int CT_IN_A = 1;
	localparam int CT_IN_B = 2;
	localparam int CT_SH_LO = 3;
	localparam int CT_SH_HI = 4;
	localparam int CT_W = 5;
	// status register bits
	localparam int STS_BUSY = 0;
	localparam int STS_PS = 1;
	localparam int STS_REJ = 2;
	localparam int STS_RANGE = 3;
	localparam int STS_MISM = 4;
	// serializer states
	typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_TAIL, S_GAP} lds_ser_t;
endpackage : lds_pkg

// file: shared/lds_shadow_if.sv
interface lds_shadow_if;
	import lds_pkg::*;
	logic wr_en; // write one mirrored word
	logic [2:0] wr_idx; // device register index
	logic [DATA_W-1:0] wr_data; // word as latched by the device
	logic clr; // device settings cleared
	logic [2:0] rd_idx; // index taken in address phase
	logic [DATA_W-1:0] rd_data; // registered read word
	modport ctl (output wr_en, wr_idx, wr_data, clr, rd_idx, input rd_data);
	modport mem (input wr_en, wr_idx, wr_data, clr, rd_idx, output rd_data);
endinterface : lds_shadow_if

// file: rtl/lds_shadow.sv
// mirror of the device's write-only registers
module lds_shadow
	import lds_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	lds_shadow_if.mem sh
);
	logic [DATA_W-1:0] word_ff [REG_COUNT]; // one word per device register
	logic [DATA_W-1:0] rd_data_ff; // read port register
	wire idx_ok = sh.rd_idx < REG_COUNT; // unmapped indices read zero

	// each word follows the device: cleared with it, loaded at latch
	for (genvar g = 0; g < REG_COUNT; g++) begin : g_word
		always_ff @(posedge i_clk) begin
			if (i_reset || sh.clr) begin
				word_ff[g] <= '0;
			end else if (sh.wr_en && sh.wr_idx == 3'(g)) begin
				word_ff[g] <= sh.wr_data;
			end
		end
	end

	// registered read, one cycle after the index
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rd_data_ff <= '0;
		end else begin
			rd_data_ff <= idx_ok ? word_ff[sh.rd_idx] : '0;
		end
	end

	assign sh.rd_data = rd_data_ff;
endmodule : lds_shadow

// file: rtl/lds_host.sv
module lds_host
	import lds_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [31:0] o_hrdata,
	output logic o_hresp,
	// supplies reported good, asynchronous pin
	input wire logic i_supply_good,
	// device pins
	output logic o_power_save_reset_n,
	output logic o_frame_sel_n,
	output logic o_serial_clk,
	output logic o_serial_data_in,
	output logic o_ctrl_in_a,
	output logic o_ctrl_in_b,
	output logic o_ctrl_in_shared_lo,
	output logic o_ctrl_in_shared_hi
);
	lds_shadow_if sh ();

	// supply pin synchroniser
	logic sup_meta_ff; // first stage, read only by second
	logic sup_ok_ff; // synchronised supply level
	// bus address phase capture
	logic a_wr_ff; // write data phase pending
	logic a_rd_ff; // read data phase pending
	logic [7:0] a_addr_ff; // byte address of the data phase
	// software registers
	logic [CT_W-1:0] ctrl_ff; // control bits
	logic rej_ff; // sticky: frame refused
	logic range_ff; // sticky: code below usable range
	// power-save pin state
	logic ps_ff; // drives the pin
	// serializer
	lds_ser_t st_ff; // serializer state
	lds_ser_t nxt_st; // next serializer state
	logic [4:0] div_ff; // half-period counter
	logic [3:0] bit_ff; // bit index in frame
	logic [FRAME_BITS-1:0] shift_ff; // outgoing bits, msb on pin
	logic [FRAME_BITS-1:0] frame_ff; // frame kept for the mirror
	logic sel_n_ff; // frame-select pin
	logic sclk_ff; // serial clock pin
	// small copies for the pairing check
	logic [1:0] pair_ff; // pairing bits as latched
	logic [CODE_W-1:0] ab_code_ff; // voltage code of channels 1/2
	logic [CODE_W-1:0] c_code_ff; // voltage code of channel 3

	// true when a code lies under its usable floor
	function automatic logic code_low(input logic [CODE_W-1:0] c,
			input logic [CODE_W-1:0] floor);
		// all-ones full-on codes sit above every floor, so never flagged
		code_low = c < floor;
	endfunction : code_low

	// routing and pairing patterns the device accepts
	function automatic logic route_ok(input logic [3:0] m);
		route_ok = (m == 4'h0) || (m[3:2] == ROUTE_LO_ONLY) ||
			(m == ROUTE_ONLY_HI);
	endfunction : route_ok

	// bus decode
	wire ahb_go = i_hsel && i_hready && i_htrans[1];
	wire wr_ctrl = a_wr_ff && a_addr_ff == OFS_CTRL;
	wire wr_frame = a_wr_ff && a_addr_ff == OFS_FRAME;
	wire wr_status = a_wr_ff && a_addr_ff == OFS_STATUS;
	wire rd_shadow = a_addr_ff[7:5] == OFS_SHADOW_HI;

	// frame word from the bus
	wire [ADDR_W-1:0] f_addr = i_hwdata[FRAME_BITS-1:DATA_W];
	wire [DATA_W-1:0] f_raw = i_hwdata[DATA_W-1:0];
	wire has_test = f_addr == RA_ROUTE || f_addr == RA_CMD;
	// test bits forced low on registers that carry them
	wire [DATA_W-1:0] f_data = has_test ? {2'h0, f_raw[TEST_LO-1:0]} : f_raw;
	wire [CODE_W-1:0] f_hi = f_data[DATA_W-1:CODE_HI_LSB];
	wire [CODE_W-1:0] f_lo = f_data[CODE_HI_LSB-1:CODE_LO_LSB];
	wire [3:0] f_route = f_data[ROUTE_HI:PAIR_LO];

	// refusal causes
	wire busy = st_ff != S_IDLE;
	wire bad_addr = f_addr >= REG_COUNT;
	wire bad_route = f_addr == RA_ROUTE && !route_ok(f_route);
	wire refuse = busy || bad_addr || bad_route || !ps_ff;
	wire accept = wr_frame && !refuse;

	// codes under the floor are sent, but flagged
	wire low_v1 = f_addr == RA_PAIR && code_low(f_hi, VOLT_MIN);
	wire low_c2 = f_addr == RA_CODES && code_low(f_hi, CURR_MIN);
	wire low_v2 = f_addr == RA_CODES && code_low(f_lo, VOLT_MIN);
	wire low_v3 = f_addr == RA_CHD && code_low(f_hi, VOLT_MIN);
	wire low_c3 = f_addr == RA_CHD && code_low(f_lo, CURR_MIN);
	wire range_hit = accept && (low_v1 || low_c2 || low_v2 || low_v3 || low_c3);

	// paired outputs need equal codes on both converters
	wire mismatch = (|pair_ff) && ab_code_ff != c_code_ff;

	// serializer timing terms
	wire half_done = div_ff == HALF_LAST;
	wire last_bit = bit_ff == BIT_LAST;
	wire latch_now = st_ff == S_TAIL && half_done;
	wire [ADDR_W-1:0] l_addr = frame_ff[FRAME_BITS-1:DATA_W];
	wire [DATA_W-1:0] l_data = frame_ff[DATA_W-1:0];

	// status word
	wire [31:0] status_w = {27'h0, mismatch, range_ff, rej_ff, ps_ff, busy};

	// supply pin passes two flops before use
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sup_meta_ff <= 1'b0;
			sup_ok_ff <= 1'b0;
		end else begin
			sup_meta_ff <= i_supply_good;
			sup_ok_ff <= sup_meta_ff;
		end
	end

	// address phase capture; sole slave, so always ready
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			a_wr_ff <= 1'b0;
			a_rd_ff <= 1'b0;
			a_addr_ff <= '0;
		end else if (i_hready) begin
			a_wr_ff <= ahb_go && i_hwrite;
			a_rd_ff <= ahb_go && !i_hwrite;
			a_addr_ff <= i_haddr[7:0];
		end
	end

	// control register
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl_ff <= '0;
		end else if (wr_ctrl) begin
			ctrl_ff <= i_hwdata[CT_W-1:0];
		end
	end

	// sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rej_ff <= 1'b0;
			range_ff <= 1'b0;
		end else begin
			rej_ff <= (wr_frame && refuse) ||
				(rej_ff && !(wr_status && i_hwdata[STS_REJ]));
			range_ff <= range_hit ||
				(range_ff && !(wr_status && i_hwdata[STS_RANGE]));
		end
	end

	// pin released only with software consent and good supplies;
	// low supplies pull it back so the device resets again
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ps_ff <= 1'b0;
		end else begin
			ps_ff <= ctrl_ff[CT_PS] && sup_ok_ff;
		end
	end

	// serializer next state; power-save low aborts a frame
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			S_IDLE: begin
				if (accept) begin
					nxt_st = S_LOW;
				end
			end
			S_LOW: begin
				if (half_done) begin
					nxt_st = S_HIGH;
				end
			end
			S_HIGH: begin
				if (half_done) begin
					nxt_st = last_bit ? S_TAIL : S_LOW;
				end
			end
			S_TAIL: begin
				if (half_done) begin
					nxt_st = S_GAP;
				end
			end
			S_GAP: begin
				if (half_done) begin
					nxt_st = S_IDLE;
				end
			end
		endcase
		if (!ps_ff) begin
			nxt_st = S_IDLE;
		end
	end

	// state and half-period counter
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_ff <= S_IDLE;
			div_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			div_ff <= (nxt_st != st_ff || half_done) ? 5'h0 : div_ff + 5'h1;
		end
	end

	// frame word and bit counter; msb first, address on top
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			shift_ff <= '0;
			frame_ff <= '0;
			bit_ff <= '0;
		end else if (accept) begin
			shift_ff <= {f_addr, f_data};
			frame_ff <= {f_addr, f_data};
			bit_ff <= '0;
		end else if (st_ff == S_HIGH && half_done && !last_bit) begin
			shift_ff <= {shift_ff[FRAME_BITS-2:0], 1'b0};
			bit_ff <= bit_ff + 4'h1;
		end
	end

	// pins: select low across the frame, data stable at rising clock
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sel_n_ff <= 1'b1;
			sclk_ff <= 1'b0;
		end else begin
			sel_n_ff <= !(nxt_st == S_LOW || nxt_st == S_HIGH ||
				nxt_st == S_TAIL);
			sclk_ff <= nxt_st == S_HIGH;
		end
	end

	// copies of pairing bits and voltage codes as the device holds them
	always_ff @(posedge i_clk) begin
		if (i_reset || !ps_ff) begin
			pair_ff <= '0;
			ab_code_ff <= '0;
			c_code_ff <= '0;
		end else if (latch_now) begin
			if (l_addr == RA_ROUTE) begin
				pair_ff <= l_data[PAIR_LO+1:PAIR_LO];
			end
			if (l_addr == RA_PAIR) begin
				ab_code_ff <= l_data[DATA_W-1:CODE_HI_LSB];
			end
			if (l_addr == RA_CODES) begin
				c_code_ff <= l_data[CODE_HI_LSB-1:CODE_LO_LSB];
			end
		end
	end

	// mirror is written at the select rise, when the device latches
	assign sh.wr_en = latch_now;
	assign sh.wr_idx = l_addr;
	assign sh.wr_data = l_data;
	assign sh.clr = !ps_ff;
	assign sh.rd_idx = i_haddr[4:2];

	lds_shadow u_shadow (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.sh(sh)
	);

	// read mux over registered sources
	wire [31:0] ctrl_w = {27'h0, ctrl_ff};
	wire [31:0] shadow_w = {20'h0, sh.rd_data};
	assign o_hrdata = !a_rd_ff ? 32'h0 :
		a_addr_ff == OFS_CTRL ? ctrl_w :
		a_addr_ff == OFS_STATUS ? status_w :
		rd_shadow ? shadow_w : 32'h0;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	// device pins
	assign o_power_save_reset_n = ps_ff;
	assign o_frame_sel_n = sel_n_ff;
	assign o_serial_clk = sclk_ff;
	assign o_serial_data_in = shift_ff[FRAME_BITS-1];
	// software alone keeps two paired steppers from moving together
	assign o_ctrl_in_a = ctrl_ff[CT_IN_A];
	assign o_ctrl_in_b = ctrl_ff[CT_IN_B];
	assign o_ctrl_in_shared_lo = ctrl_ff[CT_SH_LO];
	assign o_ctrl_in_shared_hi = ctrl_ff[CT_SH_HI];
endmodule : lds_host

// file: tb/lds_host_props.sv
// protocol checks on the controller's pins
module lds_host_props
	import lds_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_supply_good,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic o_power_save_reset_n,
	input wire logic o_frame_sel_n,
	input wire logic o_serial_clk,
	input wire logic o_serial_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	localparam int LOW_LEN = 31 * HALF_CYC; // 15 bits of two halves plus tail
	logic [9:0] low_cnt_ff; // cycles spent with select low
	logic [9:0] nxt_low_cnt;
	// count restarts whenever select is high
	assign nxt_low_cnt = o_frame_sel_n ? 10'h000 : low_cnt_ff + 10'h001;
	always_ff @(posedge i_clk) begin
		low_cnt_ff <= i_reset ? 10'h000 : nxt_low_cnt;
	end
	// one serial clock half phase
	sequence high_half_s;
		o_serial_clk throughout (##15 1'b1);
	endsequence
	sequence low_half_s;
		!o_serial_clk throughout (##15 1'b1);
	endsequence
	bus_okay_a: assert property (o_hreadyout && !o_hresp)
		else $error("bus slave not ready or not okay");
	idle_clock_a: assert property (o_frame_sel_n |-> !o_serial_clk)
		else $error("serial clock high outside a frame");
	clock_high_a: assert property ($rose(o_serial_clk) |-> high_half_s ##1 !o_serial_clk)
		else $error("serial clock high phase wrong length");
	clock_low_a: assert property ($fell(o_serial_clk) |-> low_half_s)
		else $error("serial clock low phase too short");
	data_steady_a: assert property ($changed(o_serial_data_in) && !o_frame_sel_n
		&& $past(!o_frame_sel_n) && o_power_save_reset_n |-> $fell(o_serial_clk))
		else $error("serial data moved away from clock fall");
	frame_start_a: assert property ($fell(o_frame_sel_n) |-> !o_serial_clk && o_power_save_reset_n)
		else $error("frame started with clock high or device off");
	frame_len_a: assert property ($rose(o_frame_sel_n) && o_power_save_reset_n
		|-> low_cnt_ff == LOW_LEN)
		else $error("frame select low for wrong number of cycles");
	abort_frame_a: assert property ($fell(o_power_save_reset_n) |-> ##[0:2] o_frame_sel_n)
		else $error("frame not aborted on power save");
	supply_first_a: assert property (o_power_save_reset_n |-> $past(i_supply_good, 3))
		else $error("power save released without supplies");
endmodule : lds_host_props

bind lds_host lds_host_props lds_host_props_i (.i_clk, .i_reset, .i_supply_good, .o_hreadyout,
	.o_hresp, .o_power_save_reset_n, .o_frame_sel_n, .o_serial_clk, .o_serial_data_in);

// file: tb/lds_dev_model.sv
// behavioural device: shift register and five latched words
module lds_dev_model
	import lds_pkg::*;
(
	input wire logic i_power_save_reset_n,
	input wire logic i_frame_sel_n,
	input wire logic i_serial_clk,
	input wire logic i_serial_data_in,
	output logic [4:0][DATA_W-1:0] o_regs
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [FRAME_BITS-1:0] shift_ff; // last fifteen bits seen
	// shift on clock rise while selected, msb arrives first
	always @(posedge i_serial_clk) begin
		if (!i_frame_sel_n) begin
			shift_ff <= {shift_ff[FRAME_BITS-2:0], i_serial_data_in};
		end
	end
	// power save wins over a select rise in the same instant
	always @(posedge i_frame_sel_n or negedge i_power_save_reset_n) begin
		if (!i_power_save_reset_n) begin
			o_regs <= '0;
		end else if (shift_ff[14:12] < 3'h5) begin
			o_regs[shift_ff[14:12]] <= shift_ff[DATA_W-1:0];
		end
	end
endmodule : lds_dev_model

// file: tb/tb.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb
	import lds_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic supply = 1'b0; // supplies come up late
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2; // word transfers only
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rdat; // last read word
	logic [11:0] last; // last accepted route word
	logic ok;
	wire logic hready;
	wire logic hresp;
	wire logic ps_n;
	wire logic sel_n;
	wire logic sclk;
	wire logic serial_data_in;
	wire logic pa;
	wire logic pb;
	wire logic plo;
	wire logic phi;
	wire logic [31:0] hrdata;
	wire logic [4:0][11:0] dev_regs; // device side view
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	lds_host lds_host_i (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
		.i_supply_good(supply), .o_power_save_reset_n(ps_n), .o_frame_sel_n(sel_n),
		.o_serial_clk(sclk), .o_serial_data_in(serial_data_in), .o_ctrl_in_a(pa), .o_ctrl_in_b(pb),
		.o_ctrl_in_shared_lo(plo), .o_ctrl_in_shared_hi(phi));
	lds_dev_model lds_dev_model_i (.i_power_save_reset_n(ps_n), .i_frame_sel_n(sel_n),
		.i_serial_clk(sclk), .i_serial_data_in(serial_data_in), .o_regs(dev_regs));
	// 200 mhz clock
	initial begin
		forever #2.5 i_clk = ~i_clk;
	end
	// hang guard, well above the longest run
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			final_report;
		end
	end
	task final_report;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	// one single transfer, read word lands in rdat
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		@(posedge i_clk);
		while (hready !== 1'b1) @(posedge i_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge i_clk);
		while (hready !== 1'b1) @(posedge i_clk);
		rdat = hrdata;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask : rd
	// poll busy, bounded
	task automatic wait_idle;
		int n;
		n = 0;
		bus(1'b0, OFS_STATUS, 32'h0);
		while (rdat[STS_BUSY] !== 1'b0 && n < 300) begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end
	endtask : wait_idle
	logic [14:0] frames [6] = '{15'h0d3f, 15'h1fc5, 15'h2a94, 15'h3fff, 15'h4fff, 15'h2a93};
	logic [11:0] expv [6] = '{12'h13f, 12'hfc5, 12'ha94, 12'hfff, 12'h3ff, 12'ha93};
	// main sequence
	initial begin
		repeat (10) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		`CHK({ps_n, sel_n, sclk}, 3'b010)
		rd(OFS_STATUS, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h40, 32'h0);
		bus(1'b1, OFS_FRAME, 32'h1fc0);
		rd(OFS_STATUS, 32'h4);
		`CHK(dev_regs, 60'h0)
		$display("test reset done");
		bus(1'b1, OFS_STATUS, 32'h4);
		bus(1'b1, OFS_CTRL, 32'h1);
		repeat (6) @(posedge i_clk);
		`CHK(ps_n, 1'b0)
		supply <= 1'b1;
		repeat (6) @(posedge i_clk);
		`CHK(ps_n, 1'b1)
		rd(OFS_STATUS, 32'h2);
		$display("test enable done");
		last = 12'h000;
		// every route and pairing pattern, forbidden ones refused
		for (int v = 0; v < 16; v++) begin
			ok = (v == 0) || (v == 8) || (v[3:2] == 2'h1);
			bus(1'b1, OFS_FRAME, {22'h0, 4'(v), 6'h15});
			wait_idle;
			`CHK(rdat[STS_REJ], !ok)
			if (ok)
				last = {2'h0, 4'(v), 6'h15};
			`CHK(dev_regs[0], last)
			bus(1'b1, OFS_STATUS, 32'h4);
		end
		$display("test route done");
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, OFS_FRAME, {17'h0, frames[i]});
			// the last frame carries a voltage code under its floor
			rd(OFS_STATUS, (i == 5) ? 32'hb : 32'h3);
			wait_idle;
			`CHK(dev_regs[frames[i][14:12]], expv[i])
			rd({3'h1, frames[i][14:12], 2'h0}, {20'h0, expv[i]});
		end
		rd(OFS_STATUS, 32'ha);
		bus(1'b1, OFS_STATUS, 32'hc);
		bus(1'b1, OFS_FRAME, 32'h5000);
		rd(OFS_STATUS, 32'h6);
		bus(1'b1, OFS_STATUS, 32'h4);
		// paired drive while the two voltage codes differ is reported
		bus(1'b1, OFS_FRAME, 32'h0155);
		wait_idle;
		`CHK(rdat, 32'h12)
		$display("test frames done");
		bus(1'b1, OFS_CTRL, 32'h0b);
		@(posedge i_clk);
		`CHK({phi, plo, pb, pa}, 4'h5)
		rd(OFS_CTRL, 32'h0b);
		bus(1'b1, OFS_CTRL, 32'h15);
		@(posedge i_clk);
		`CHK({phi, plo, pb, pa}, 4'ha)
		$display("test pins done");
		// power save in mid frame
		bus(1'b1, OFS_FRAME, 32'h1abc);
		repeat (100) @(posedge i_clk);
		bus(1'b1, OFS_CTRL, 32'h0);
		repeat (4) @(posedge i_clk);
		`CHK({ps_n, sel_n}, 2'b01)
		`CHK(dev_regs, 60'h0)
		rd(8'h28, 32'h0);
		$display("test abort done");
		final_report;
	end
endmodule : tb
